// ==== common/ltp_pkg.sv ====
`default_nettype none
package ltp_pkg;
   localparam int unsigned CLK_HZ = 20_000_000;
   localparam int unsigned POLL_TIME_S = 4;
   localparam int unsigned POLL_CYCLES = POLL_TIME_S * CLK_HZ;
   localparam logic [6:0] LIGHT_ADDR_RST = 7'h44;
   localparam logic [6:0] TEMP_ADDR_RST = 7'h4C;
   localparam logic [15:0] DIV_RST = 16'h00F0;
   localparam logic [15:0] CFG_WORD = (16'hC << 12) | (16'h3 << 9);
   localparam logic [7:0] PTR_LCFG = 8'h01;
   localparam logic [7:0] PTR_LRES = 8'h00;
   localparam logic [7:0] PTR_THI = 8'h01;
   localparam logic [7:0] PTR_TLO = 8'h10;
   localparam logic [7:0] PEND_SET = 8'hFF;
   localparam logic [15:0] LUX100 = 16'h29C4;
   localparam logic [7:0] TEMP_ALARM = 8'h32;
   localparam int CTL_SWRST = 0;
   localparam logic [31:0] CTL_FIXED = 32'h0000_08C0;
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_TADDR = 8'h08;
   localparam logic [7:0] OFS_DIV = 8'h10;
   localparam logic [7:0] OFS_IE = 8'h18;
   localparam logic [7:0] OFS_DATA = 8'h20;
   localparam logic [2:0] STEP_LOOP = 3'h3;
   localparam logic [2:0] STEP_CFGRD = 3'h1;
   localparam logic [2:0] STEP_THI = 3'h5;
   localparam logic [2:0] STEP_LAST = 3'h7;
   typedef struct packed {
      logic port;
      logic rx;
      logic [1:0] txn;
      logic [1:0] rxn;
      logic [0:2][7:0] tx_byte_array;
   } ltp_txn_s;
endpackage : ltp_pkg
`default_nettype wire

// ==== hw/ltp_poller.sv ====
// Local design decisions: the address map and the APB register port.
`default_nettype none
module ltp_poller #(
   parameter int unsigned POLL_CYC = ltp_pkg::POLL_CYCLES
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic light_scl_i,
   input wire logic light_sda_i,
   input wire logic temp_scl_i,
   input wire logic temp_sda_i,
   output logic light_scl_o,
   output logic light_scl_oe_n,
   output logic light_sda_o,
   output logic light_sda_oe_n,
   output logic temp_scl_o,
   output logic temp_scl_oe_n,
   output logic temp_sda_o,
   output logic temp_sda_oe_n,
   output logic drive_current_high,
   output logic over_temp,
   output logic [3:0] light_exponent,
   output logic [11:0] light_mantissa,
   output logic [7:0] temp_whole,
   output logic [3:0] temp_frac
);
   typedef enum logic [3:0] {
      E_IDLE = 4'h1, E_START = 4'h2, E_BYTE = 4'h4, E_STOP = 4'h8
   } ltp_eng_e;
   typedef enum logic [3:0] {
      Q_OFF = 4'h1, Q_LAUNCH = 4'h2, Q_BUSY = 4'h4, Q_WAIT = 4'h8
   } ltp_seq_e;

   // fixed transfer plan: init steps 0..2, then polled loop 3..7
   function automatic ltp_pkg::ltp_txn_s step_txn(input logic [2:0] s);
      ltp_pkg::ltp_txn_s t;
      t = '0;
      case (s)
         3'h0: t = {2'b00, 2'h3, 2'h0, ltp_pkg::PTR_LCFG, ltp_pkg::CFG_WORD};
         3'h1: t = {2'b01, 2'h0, 2'h2, 24'h0};
         3'h2: t = {2'b00, 2'h1, 2'h0, ltp_pkg::PTR_LRES, 16'h0};
         3'h3: t = {2'b01, 2'h0, 2'h2, 24'h0};
         3'h4: t = {2'b10, 2'h1, 2'h1, ltp_pkg::PTR_THI, 16'h0};
         3'h5: t = {2'b11, 2'h1, 2'h1, ltp_pkg::PTR_THI, 16'h0};
         3'h6: t = {2'b10, 2'h1, 2'h1, ltp_pkg::PTR_TLO, 16'h0};
         default: t = {2'b11, 2'h1, 2'h1, ltp_pkg::PTR_TLO, 16'h0};
      endcase
      return t;
   endfunction : step_txn

   logic [1:0] swrst;
   logic [1:0][6:0] target_addr_reg;
   logic [1:0][15:0] port_divider;
   logic [1:0][1:0] port_irq_enable;
   logic [3:0] s1;
   logic [3:0] s2;
   ltp_eng_e eng;
   ltp_seq_e seq;
   ltp_pkg::ltp_txn_s cur;
   logic [1:0] phase;
   logic [3:0] bitn;
   logic [8:0] sh;
   logic scl_low;
   logic sda_low;
   logic addr_ph;
   logic nack;
   logic done;
   logic [1:0] port_flags;
   logic [1:0] tx_remaining_count;
   logic [1:0] tx_idx;
   logic [1:0] rx_expected_count;
   logic [1:0] rx_idx;
   logic [1:0][7:0] rx_buf;
   logic [13:0] qcnt;
   logic [2:0] step;
   logic [31:0] poll_cnt;
   logic due;
   logic [7:0] pending_command_flag;
   logic [15:0] cfg_back;
   logic [15:0] light_result;
   logic [7:0] temp_lo;

   // bus decode
   wire logic acc = psel & penable;
   wire logic wr_en = acc & pready & pwrite;
   wire logic pi = paddr[2];
   wire logic [7:0] ofs = {paddr[7:3], 3'b000};
   wire logic hit = (paddr[1:0] == 2'b00) & ((ofs == ltp_pkg::OFS_CTRL)
      | (ofs == ltp_pkg::OFS_TADDR) | (ofs == ltp_pkg::OFS_DIV)
      | (ofs == ltp_pkg::OFS_IE) | (ofs == ltp_pkg::OFS_DATA));
   wire logic [31:0] light_data = {cfg_back, light_result};
   wire logic [31:0] temp_data = {pending_command_flag, 5'h0, seq != Q_OFF,
      nack, over_temp, temp_whole, temp_lo};
   wire logic [31:0] rd_val =
      (ofs == ltp_pkg::OFS_CTRL) ? (ltp_pkg::CTL_FIXED | {31'h0, swrst[pi]}) :
      (ofs == ltp_pkg::OFS_TADDR) ? {25'h0, target_addr_reg[pi]} :
      (ofs == ltp_pkg::OFS_DIV) ? {16'h0, port_divider[pi]} :
      (ofs == ltp_pkg::OFS_IE) ? {30'h0, port_irq_enable[pi]} :
      (ofs == ltp_pkg::OFS_DATA) ? (pi ? temp_data : light_data) : 32'h0;

   // engine helpers
   wire logic run = ~|swrst & (&port_irq_enable);
   wire logic scl_s = cur.port ? s2[2] : s2[0];
   wire logic sda_s = cur.port ? s2[3] : s2[1];
   wire logic [15:0] cdiv = port_divider[cur.port];
   wire logic q_end = (cdiv[15:2] == 14'h0) | (qcnt == cdiv[15:2] - 14'h1);
   // a target holding the clock low stretches the quarter after release
   wire logic tick = q_end & ~((phase == 2'h2) & ~scl_s & (eng != E_IDLE));
   wire logic byte_end = (eng == E_BYTE) & tick & (phase == 2'h3) & (bitn == 4'h8);
   wire logic ack_bad = (~cur.rx | addr_ph) & sh[0];
   wire logic [1:0] nxt_rx = addr_ph ? 2'h0 : rx_idx + 2'h1;
   wire logic last_rx = (nxt_rx + 2'h1 == rx_expected_count);
   wire logic [7:0] tx_next = cur.tx_byte_array[tx_idx];
   wire logic launch = (seq == Q_LAUNCH);
   wire logic ok_done = (seq == Q_BUSY) & done & ~nack;
   wire logic [15:0] rx_word = {rx_buf[0], rx_buf[1]};
   wire logic poll_wrap = run & (poll_cnt == 32'(POLL_CYC - 1));

   always_ff @(posedge ref_clk) begin
      s1 <= {temp_sda_i, temp_scl_i, light_sda_i, light_scl_i};
      s2 <= s1;
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         swrst <= 2'b11;
         target_addr_reg <= {ltp_pkg::TEMP_ADDR_RST, ltp_pkg::LIGHT_ADDR_RST};
         port_divider <= {ltp_pkg::DIV_RST, ltp_pkg::DIV_RST};
         port_irq_enable <= 4'h0;
      end else if (wr_en) begin
         if (ofs == ltp_pkg::OFS_CTRL) begin
            swrst[pi] <= pwdata[ltp_pkg::CTL_SWRST];
         end
         if (ofs == ltp_pkg::OFS_TADDR) begin
            target_addr_reg[pi] <= pwdata[6:0];
         end
         if (ofs == ltp_pkg::OFS_DIV) begin
            port_divider[pi] <= pwdata[15:0];
         end
         if (ofs == ltp_pkg::OFS_IE) begin
            port_irq_enable[pi] <= pwdata[1:0];
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0;
      end else begin
         pready <= acc & ~pready;
         pslverr <= acc & ~pready & ~hit;
         prdata <= (acc & ~pready & ~pwrite & hit) ? rd_val : 32'h0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst | (eng == E_IDLE) | tick) begin
         qcnt <= 14'h0;
      end else if (!q_end) begin
         qcnt <= qcnt + 14'h1;
      end
   end

   // byte engine: four quarters per bit, nine bits per byte incl. acknowledge
   always_ff @(posedge ref_clk) begin
      if (rst | ~run) begin
         eng <= E_IDLE;
         cur <= '0;
         phase <= 2'h0;
         bitn <= 4'h0;
         sh <= 9'h1FF;
         scl_low <= 1'b0;
         sda_low <= 1'b0;
         addr_ph <= 1'b0;
         nack <= 1'b0;
         done <= 1'b0;
         port_flags <= 2'h0;
         tx_remaining_count <= 2'h0;
         tx_idx <= 2'h0;
         rx_expected_count <= 2'h0;
         rx_idx <= 2'h0;
         rx_buf <= '0;
      end else begin
         done <= 1'b0;
         port_flags <= 2'h0;
         if (launch) begin
            cur <= step_txn(step);
            tx_remaining_count <= step_txn(step).txn;
            rx_expected_count <= step_txn(step).rxn;
            tx_idx <= 2'h0;
            rx_idx <= 2'h0;
            nack <= 1'b0;
            phase <= 2'h0;
            eng <= E_START;
         end else if (tick) begin
            phase <= phase + 2'h1;
            case (eng)
               E_START: begin
                  case (phase)
                     2'h1: sda_low <= 1'b1;
                     2'h2: scl_low <= 1'b1;
                     2'h3: begin
                        sh <= {target_addr_reg[cur.port], cur.rx, 1'b1};
                        bitn <= 4'h0;
                        addr_ph <= 1'b1;
                        eng <= E_BYTE;
                     end
                     default: scl_low <= 1'b0;
                  endcase
               end
               E_BYTE: begin
                  case (phase)
                     2'h0: sda_low <= ~sh[8];
                     2'h1: scl_low <= 1'b0;
                     2'h2: sh <= {sh[7:0], sda_s};
                     default: begin
                        scl_low <= 1'b1;
                        bitn <= bitn + 4'h1;
                     end
                  endcase
                  if (byte_end) begin
                     bitn <= 4'h0;
                     addr_ph <= 1'b0;
                     if (ack_bad) begin
                        nack <= 1'b1;
                        eng <= E_STOP;
                     end else if (cur.rx) begin
                        if (!addr_ph) begin
                           rx_buf[rx_idx] <= sh[8:1];
                           rx_idx <= rx_idx + 2'h1;
                           port_flags[0] <= 1'b1;
                        end
                        if (!addr_ph & (rx_idx + 2'h1 == rx_expected_count)) begin
                           eng <= E_STOP;
                        end else begin
                           sh <= {8'hFF, last_rx};
                        end
                     end else begin
                        port_flags[1] <= 1'b1;
                        if (tx_remaining_count == 2'h0) begin
                           eng <= E_STOP;
                        end else begin
                           sh <= {tx_next, 1'b1};
                           tx_idx <= tx_idx + 2'h1;
                           tx_remaining_count <= tx_remaining_count - 2'h1;
                        end
                     end
                  end
               end
               E_STOP: begin
                  case (phase)
                     2'h0: sda_low <= 1'b1;
                     2'h1: scl_low <= 1'b0;
                     2'h2: sda_low <= 1'b0;
                     default: begin
                        eng <= E_IDLE;
                        done <= 1'b1;
                     end
                  endcase
               end
               default: phase <= 2'h0;
            endcase
         end
      end
   end

   // sequencer
   always_ff @(posedge ref_clk) begin
      if (rst | ~run) begin
         seq <= Q_OFF;
         step <= 3'h0;
         poll_cnt <= 32'h0;
         due <= 1'b0;
         pending_command_flag <= 8'h00;
      end else begin
         poll_cnt <= poll_wrap ? 32'h0 : poll_cnt + 32'h1;
         due <= poll_wrap | (due & ~(seq == Q_WAIT));
         case (seq)
            Q_OFF: seq <= Q_LAUNCH;
            Q_LAUNCH: begin
               seq <= Q_BUSY;
               if (step_txn(step).port) begin
                  pending_command_flag <= ltp_pkg::PEND_SET;
               end
            end
            Q_BUSY: begin
               if (done) begin
                  pending_command_flag <= 8'h00;
                  if (nack) begin
                     seq <= Q_WAIT;
                     step <= (step < ltp_pkg::STEP_LOOP) ? 3'h0 : ltp_pkg::STEP_LOOP;
                  end else if (step == ltp_pkg::STEP_LAST) begin
                     seq <= Q_WAIT;
                     step <= ltp_pkg::STEP_LOOP;
                  end else begin
                     seq <= Q_LAUNCH;
                     step <= step + 3'h1;
                  end
               end
            end
            Q_WAIT: begin
               if (due) begin
                  seq <= Q_LAUNCH;
               end
            end
            default: seq <= Q_OFF;
         endcase
      end
   end

   // results are committed only from a fully acknowledged transfer
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cfg_back <= 16'h0;
         light_result <= 16'h0;
         light_exponent <= 4'h0;
         light_mantissa <= 12'h0;
         drive_current_high <= 1'b0;
         temp_whole <= 8'h0;
         over_temp <= 1'b0;
         temp_lo <= 8'h0;
         temp_frac <= 4'h0;
      end else if (ok_done) begin
         if (step == ltp_pkg::STEP_CFGRD) begin
            cfg_back <= rx_word;
         end
         if (step == ltp_pkg::STEP_LOOP) begin
            light_result <= rx_word;
            light_exponent <= rx_word[15:12];
            light_mantissa <= rx_word[11:0];
            if (rx_word > ltp_pkg::LUX100) begin
               drive_current_high <= 1'b1;
            end else if (rx_word < ltp_pkg::LUX100) begin
               drive_current_high <= 1'b0;
            end
         end
         if (step == ltp_pkg::STEP_THI) begin
            temp_whole <= rx_buf[0];
            over_temp <= rx_buf[0] > ltp_pkg::TEMP_ALARM;
         end
         if (step == ltp_pkg::STEP_LAST) begin
            temp_lo <= rx_buf[0];
            temp_frac <= rx_buf[0][7:4];
         end
      end
   end

   // open-drain pins: only the active port pulls low
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         {light_scl_o, light_sda_o, temp_scl_o, temp_sda_o} <= 4'h0;
         {light_scl_oe_n, light_sda_oe_n, temp_scl_oe_n, temp_sda_oe_n} <= 4'hF;
      end else begin
         {light_scl_o, light_sda_o, temp_scl_o, temp_sda_o} <= 4'h0;
         light_scl_oe_n <= ~(scl_low & ~cur.port);
         light_sda_oe_n <= ~(sda_low & ~cur.port);
         temp_scl_oe_n <= ~(scl_low & cur.port);
         temp_sda_oe_n <= ~(sda_low & cur.port);
      end
   end

   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);

   property p_light_addr;
      $fell(rst) |-> target_addr_reg[0] == ltp_pkg::LIGHT_ADDR_RST;
   endproperty
   a_light_addr: assert property (p_light_addr) else $error("light address wrong");
   property p_temp_addr;
      $fell(rst) |-> target_addr_reg[1] == ltp_pkg::TEMP_ADDR_RST;
   endproperty
   a_temp_addr: assert property (p_temp_addr) else $error("temp address wrong");
   property p_tx_count;
      port_flags[1] && $past(tx_remaining_count) != 2'h0
         |-> tx_remaining_count == $past(tx_remaining_count) - 2'h1;
   endproperty
   a_tx_count: assert property (p_tx_count) else $error("tx count not stepped");
   property p_rx_count;
      done && cur.rx && !nack |-> rx_idx == rx_expected_count;
   endproperty
   a_rx_count: assert property (p_rx_count) else $error("rx count short");
   property p_dir_bit;
      eng == E_START && tick && phase == 2'h3 |=> eng == E_BYTE && sh[1] == cur.rx;
   endproperty
   a_dir_bit: assert property (p_dir_bit) else $error("direction bit wrong");
   property p_bright;
      ok_done && step == ltp_pkg::STEP_LOOP && rx_word > ltp_pkg::LUX100
         |=> drive_current_high;
   endproperty
   a_bright: assert property (p_bright) else $error("current not raised");
   property p_alarm;
      over_temp == (temp_whole > ltp_pkg::TEMP_ALARM);
   endproperty
   a_alarm: assert property (p_alarm) else $error("alarm mismatch");
   property p_quarter;
      tick && cdiv == ltp_pkg::DIV_RST |=> !tick [*8];
   endproperty
   a_quarter: assert property (p_quarter) else $error("bit rate too fast");
   property p_keep;
      done && nack |=> $stable(light_result) && $stable(temp_whole);
   endproperty
   a_keep: assert property (p_keep) else $error("value lost on nack");
endmodule : ltp_poller
`default_nettype wire

// ==== dv/ltp_sensor_model.sv ====
`default_nettype none
module ltp_sensor_model #(
   parameter logic [6:0] ADDR = 7'h00,
   parameter bit W2 = 1'b0
) (
   input wire logic scl,
   input wire logic sda,
   input wire logic nack,
   output logic sda_oe_n
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] regs [0:255];
   logic [7:0] wlog [$];
   logic [7:0] sh;
   logic [7:0] ptr;
   logic [7:0] rd_byte;
   logic [7:0] snap;
   int st;
   int bc;
   int wi;
   int rk;
   initial begin
      sda_oe_n = 1'b1;
      st = 0;
      bc = 0;
      ptr = 8'h00;
      snap = 8'h00;
   end
   always @(negedge sda) if (scl === 1'b1) begin
      st = 1;
      bc = 0;
   end
   always @(posedge sda) if (scl === 1'b1) begin
      st = 0;
      sda_oe_n = 1'b1;
   end
   always @(posedge scl) if (st != 0) begin
      if (bc < 8) sh = {sh[6:0], sda};
      else if (st == 3 && sda === 1'b1) st = 0;
      bc++;
   end
   // acknowledge after eight bits, then shift out read data msb first
   always @(negedge scl) if (st != 0) begin
      if (bc == 8) begin
         sda_oe_n = 1'b1;
         if (st == 1) begin
            if (sh[7:1] == ADDR && !nack) begin
               sda_oe_n = 1'b0;
               st = sh[0] ? 3 : 2;
               wi = 0;
               rk = 0;
            end else st = 0;
         end else if (st == 2) begin
            sda_oe_n = 1'b0;
            wlog.push_back(sh);
            if (wi == 0) ptr = sh;
            else if (wi == 1) regs[ptr][15:8] = sh;
            else regs[ptr][7:0] = sh;
            wi++;
         end
      end else if (bc == 9) begin
         bc = 0;
         sda_oe_n = 1'b1;
         if (st == 3) begin
            if (W2) rd_byte = (rk == 0) ? regs[ptr][15:8] : regs[ptr][7:0];
            else if (ptr == 8'h10) rd_byte = snap;
            else begin
               rd_byte = regs[ptr][7:0];
               snap = regs[8'h10][7:0];
            end
            rk++;
         end
      end
      if (st == 3 && bc < 8) sda_oe_n = rd_byte[7 - bc];
   end
endmodule : ltp_sensor_model
`default_nettype wire

// ==== dv/ltp_poller_tb.sv ====
`default_nettype none
module ltp_poller_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned POLL = 15000;
   logic ref_clk, rst, psel, penable, pwrite, pready, pslverr, e, t_nack;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic light_scl_o, light_scl_oe_n, light_sda_o, light_sda_oe_n, lm_oe_n, tm_oe_n;
   logic temp_scl_o, temp_scl_oe_n, temp_sda_o, temp_sda_oe_n, drive_current_high, over_temp;
   logic [3:0] light_exponent, temp_frac;
   logic [11:0] light_mantissa;
   logic [7:0] temp_whole;
   wire logic l_scl, l_sda, t_scl, t_sda;
   int fails, total_checks;
   time t0;
   // pulled-up open-drain wires
   assign l_scl = light_scl_oe_n | light_scl_o;
   assign l_sda = (light_sda_oe_n | light_sda_o) & lm_oe_n;
   assign t_scl = temp_scl_oe_n | temp_scl_o;
   assign t_sda = (temp_sda_oe_n | temp_sda_o) & tm_oe_n;
   ltp_poller #(.POLL_CYC(POLL)) u_ltp_poller (.ref_clk, .rst, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .light_scl_i(l_scl), .light_sda_i(l_sda),
      .temp_scl_i(t_scl), .temp_sda_i(t_sda), .light_scl_o, .light_scl_oe_n, .light_sda_o,
      .light_sda_oe_n, .temp_scl_o, .temp_scl_oe_n, .temp_sda_o, .temp_sda_oe_n,
      .drive_current_high, .over_temp, .light_exponent, .light_mantissa, .temp_whole,
      .temp_frac);
   ltp_sensor_model #(.ADDR(7'h44), .W2(1'b1)) u_ltp_sensor_model_l (.scl(l_scl),
      .sda(l_sda), .nack(1'b0), .sda_oe_n(lm_oe_n));
   ltp_sensor_model #(.ADDR(7'h4C), .W2(1'b0)) u_ltp_sensor_model_t (.scl(t_scl),
      .sda(t_sda), .nack(t_nack), .sda_oe_n(tm_oe_n));
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   task automatic close_out();
      if (fails == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : close_out
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      total_checks++;
      if (g !== x) begin
         fails++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, g, x);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         fails++;
         $display("CHECK FAILED at %0t: no bus answer", $time);
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask : apb
   task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
      apb(1'b0, a, 32'h0000_0000);
      chk(r, x);
      chk(32'(e), 32'(xe));
   endtask : rd
   initial begin
      fails = 0;
      total_checks = 0;
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      t_nack = 1'b0;
      u_ltp_sensor_model_l.regs[0] = 16'h29C5;
      u_ltp_sensor_model_t.regs[1] = 16'h0032;
      u_ltp_sensor_model_t.regs[16] = 16'h00A0;
      repeat (12) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      rd(8'h00, 32'h0000_08C1, 1'b0);
      rd(8'h04, 32'h0000_08C1, 1'b0);
      rd(8'h08, 32'h0000_0044, 1'b0);
      rd(8'h0C, 32'h0000_004C, 1'b0);
      rd(8'h10, 32'h0000_00F0, 1'b0);
      rd(8'h14, 32'h0000_00F0, 1'b0);
      rd(8'h18, 32'h0000_0000, 1'b0);
      rd(8'h30, 32'h0000_0000, 1'b1);
      rd(8'h02, 32'h0000_0000, 1'b1);
      // faster temperature port keeps the run short
      apb(1'b1, 8'h14, 32'h0000_0040);
      apb(1'b1, 8'h00, 32'h0000_0000);
      apb(1'b1, 8'h04, 32'h0000_0000);
      apb(1'b1, 8'h18, 32'h0000_0003);
      apb(1'b1, 8'h1C, 32'h0000_0003);
      @(negedge l_scl);
      @(posedge l_scl);
      t0 = $time;
      @(posedge l_scl);
      chk(32'($time - t0), 32'(12000));
      for (int i = 0; i < 60000 && temp_frac !== 4'hA; i++) @(posedge ref_clk);
      u_ltp_sensor_model_l.regs[0] = 16'h29C3;
      u_ltp_sensor_model_t.regs[1] = 16'h0033;
      u_ltp_sensor_model_t.regs[16] = 16'h0050;
      chk(32'(light_exponent), 32'h0000_0002);
      chk(32'(light_mantissa), 32'h0000_09C5);
      chk(32'(drive_current_high), 32'h0000_0001);
      chk(32'(temp_whole), 32'h0000_0032);
      chk(32'(over_temp), 32'h0000_0000);
      rd(8'h20, 32'hC600_29C5, 1'b0);
      chk(32'(u_ltp_sensor_model_l.wlog.size()), 32'h0000_0004);
      chk(32'({u_ltp_sensor_model_l.wlog[0], u_ltp_sensor_model_l.wlog[1],
         u_ltp_sensor_model_l.wlog[2], u_ltp_sensor_model_l.wlog[3]}), 32'h01C6_0000);
      chk(32'({u_ltp_sensor_model_t.wlog[0], u_ltp_sensor_model_t.wlog[1]}),
         32'h0000_0110);
      for (int i = 0; i < 40000 && temp_frac !== 4'h5; i++) @(posedge ref_clk);
      chk(32'(light_mantissa), 32'h0000_09C3);
      chk(32'(drive_current_high), 32'h0000_0000);
      chk(32'(over_temp), 32'h0000_0001);
      apb(1'b0, 8'h24, 32'h0000_0000);
      chk(r & 32'h0001_FFFF, 32'h0001_3350);
      chk(32'(u_ltp_sensor_model_l.wlog.size()), 32'h0000_0004);
      chk(32'({u_ltp_sensor_model_t.wlog[2], u_ltp_sensor_model_t.wlog[3]}),
         32'h0000_0110);
      t_nack <= 1'b1;
      u_ltp_sensor_model_l.regs[0] = 16'h4000;
      for (int i = 0; i < 40000 && light_exponent !== 4'h4; i++) @(posedge ref_clk);
      for (int i = 0; i < 5000; i++) begin
         apb(1'b0, 8'h24, 32'h0000_0000);
         if (r[17] === 1'b1) break;
      end
      chk(32'(r[17]), 32'h0000_0001);
      chk(32'({temp_whole, temp_frac, over_temp}), 32'h0000_066B);
      chk(32'(drive_current_high), 32'h0000_0001);
      close_out();
   end
   initial begin
      repeat (100000) @(posedge ref_clk);
      fails++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      close_out();
   end
endmodule : ltp_poller_tb
`default_nettype wire
